// ===== dsc_regs.svh
// Register offsets, field positions, status codes and reset values of the slave DMA channels.
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH

`define DSC_MAX_CH        15
`define DSC_CSR_BASE      2'h0
`define DSC_ADR_BASE      2'h1
`define DSC_CMD_OFF       8'h80
`define DSC_TBASE_OFF     8'h84

`define DSC_ST_MSB        31
`define DSC_ST_LSB        28
`define DSC_SLAVE_BIT     27
`define DSC_SYSMEM_BIT    26
`define DSC_DIR_BIT       24
`define DSC_CRN_MSB       23
`define DSC_CRN_LSB       20
`define DSC_LEN_MSB       19
`define DSC_LEN_LSB       0
`define DSC_TCE_MSB       31
`define DSC_TCE_LSB       12
`define DSC_OFS_MSB       11
`define DSC_CMD_EN_BIT    4

`define DSC_ST_DIS        4'h0
`define DSC_ST_EN         4'h1
`define DSC_ERR_TCE       4'h2
`define DSC_ERR_MEM       4'h3
`define DSC_ERR_DEV       4'h4
`define DSC_ERR_CRN       4'h5

`define DSC_RESET_WORD    32'h0000_0000
`define DSC_ENTRY_BYTES   3'h4

`endif

// ===== dsc_pkg.sv
// Types shared by the slave DMA channel controller and its surroundings.
`include "dsc_regs.svh"

package dsc_pkg;

   typedef enum logic [2:0] {
      S_IDLE,
      S_CHECK,
      S_TCE,
      S_SRC,
      S_DST
   } dsc_fsm_type;

   // One request to the bus cycle engine; held until ack or err.
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic        write;
      logic        dev;
      logic        sys;
      logic [2:0]  size;
      logic [31:0] wdata;
   } dsc_bus_req_type;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } dsc_bus_rsp_type;

   typedef struct packed {
      logic                              dp_wr;
      logic [7:0]                        dp_addr;
      logic [31:0]                       hrdata;
      logic [5:0]                        sy1;
      logic [5:0]                        sy2;
      logic [5:0]                        sy3;
      logic [5:0]                        stab;
      logic                              gprev;
      logic [`DSC_MAX_CH-1:0][31:0]      channel_status_control;
      logic [`DSC_MAX_CH-1:0][31:0]      adr;
      logic [31:0]                       tbase;
      dsc_fsm_type                       fsm;
      logic [3:0]                        lvl;
      logic [3:0]                        crn;
      logic [31:0]                       wadr;
      logic [19:0]                       wlen;
      logic [2:0]                        size;
      logic [31:0]                       data;
      logic                              tv;
      logic [19:0]                       ttag;
      logic [3:0]                        tcrn;
      logic [19:0]                       real_page_number;
      dsc_bus_req_type                   req;
      logic                              tc;
   } dsc_state_type;

endpackage

// ===== dsc_channel_ctrl.sv
// Slave DMA channel controller: channel registers on AHB-Lite and the transfer sequencer.
`timescale 1ns/1ps
`include "dsc_regs.svh"

module dsc_channel_ctrl #(
   parameter int NUM_CH = 15
) (
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     ce,
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output      logic                     hreadyout,
   output      logic                     hresp,
   output      logic [31:0]              hrdata,
   input  wire logic                     grant_pin,
   input  wire logic [3:0]               level_pin,
   input  wire logic                     burst_pin,
   input  wire logic [2:0]               dev_width,
   output      dsc_pkg::dsc_bus_req_type bus_req,
   input  wire dsc_pkg::dsc_bus_rsp_type bus_rsp,
   output      logic                     tc
);
   import dsc_pkg::*;

   dsc_state_type q;
   dsc_state_type d;

   ////////////////////////////////////////////////////////////////////////////////
   // Transfer size: device width, cut down for a misaligned address or a short tail.

   function automatic logic [2:0] xfer_size(input logic [1:0]  a,
                                           input logic [2:0]  w,
                                           input logic [19:0] len);
      logic [2:0] s;
      s = 3'h1;
      if (w == 3'h4)
      begin
         if (a == 2'h0)
            s = 3'h4;
         else if (a == 2'h2)
            s = 3'h2;
      end
      else if (w == 3'h2 && a[0] == 1'b0)
         s = 3'h2;
      if (len == 20'h0)
         s = 3'h1;
      else if (s == 3'h4 && len < 20'h3)
         s = 3'h2;
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb
   begin
      logic        ap;
      logic        rise;
      logic [3:0]  idx;
      logic [31:0] cs;
      logic [31:0] pa;
      logic        sysm;
      logic        dir;
      logic [3:0]  ecode;
      logic        fail;
      ap    = 1'b0;
      rise  = 1'b0;
      idx   = 4'h0;
      cs    = 32'h0;
      pa    = 32'h0;
      sysm  = 1'b0;
      dir   = 1'b0;
      ecode = `DSC_ST_DIS;
      fail  = 1'b0;
      d     = q;

      // Pins pass three flops; a bit only changes once the second and third agree.
      d.sy1  = {burst_pin, grant_pin, level_pin};
      d.sy2  = q.sy1;
      d.sy3  = q.sy2;
      d.stab = (q.stab & (q.sy2 ^ q.sy3)) | (q.sy2 & ~(q.sy2 ^ q.sy3));
      d.gprev = q.stab[4];
      rise    = q.stab[4] & ~q.gprev;

      // Read data is looked up in the address phase so the slave never waits.
      ap = hsel & hready & htrans[1];
      d.dp_wr = ap & hwrite;
      if (ap)
      begin
         d.dp_addr = haddr[7:0];
         idx = haddr[5:2];
         if (!hwrite)
         begin
            d.hrdata = 32'h0;
            if (haddr[7:6] == `DSC_CSR_BASE && 32'(idx) < NUM_CH)
               d.hrdata = q.channel_status_control[idx];
            else if (haddr[7:6] == `DSC_ADR_BASE && 32'(idx) < NUM_CH)
               d.hrdata = q.adr[idx];
            else if (haddr[7:0] == `DSC_TBASE_OFF)
               d.hrdata = q.tbase;
         end
      end

      // Software stores; hardware updates below override them in the same cycle.
      if (q.dp_wr)
      begin
         idx = q.dp_addr[5:2];
         if (q.dp_addr[7:6] == `DSC_CSR_BASE && 32'(idx) < NUM_CH)
            d.channel_status_control[idx] = hwdata;
         else if (q.dp_addr[7:6] == `DSC_ADR_BASE && 32'(idx) < NUM_CH)
         begin
            d.adr[idx] = hwdata;
            d.tv = 1'b0;
         end
         else if (q.dp_addr == `DSC_TBASE_OFF)
         begin
            d.tbase = hwdata;
            d.tv = 1'b0;
         end
         else if (q.dp_addr == `DSC_CMD_OFF && 32'(hwdata[3:0]) < NUM_CH)
         begin
            idx = hwdata[3:0];
            if (hwdata[`DSC_CMD_EN_BIT])
            begin
               // An errored channel stays errored.
               if (q.channel_status_control[idx][`DSC_ST_MSB:`DSC_ST_LSB] == `DSC_ST_DIS)
                  d.channel_status_control[idx][`DSC_ST_MSB:`DSC_ST_LSB] = `DSC_ST_EN;
            end
            else if (q.channel_status_control[idx][`DSC_ST_MSB:`DSC_ST_LSB] == `DSC_ST_EN)
               d.channel_status_control[idx][`DSC_ST_MSB:`DSC_ST_LSB] = `DSC_ST_DIS;
         end
      end

      cs   = q.channel_status_control[q.lvl];
      sysm = cs[`DSC_SYSMEM_BIT];
      dir  = cs[`DSC_DIR_BIT];
      // Bus memory uses the raw address; system memory joins page and offset.
      pa = sysm ? {q.real_page_number, q.wadr[`DSC_OFS_MSB:0]} : q.wadr;

      unique case (q.fsm)
         S_IDLE:
         begin
            if (rise)
            begin
               d.lvl = q.stab[3:0];
               d.fsm = S_CHECK;
            end
         end
         S_CHECK:
         begin
            // Only an enabled slave channel is served; errored ones are skipped.
            d.fsm = S_IDLE;
            if (32'(q.lvl) < NUM_CH && cs[`DSC_SLAVE_BIT]
                && cs[`DSC_ST_MSB:`DSC_ST_LSB] == `DSC_ST_EN)
            begin
               if (32'(cs[`DSC_CRN_MSB:`DSC_CRN_LSB]) >= NUM_CH)
                  d.channel_status_control[q.lvl][`DSC_ST_MSB:`DSC_ST_LSB] = `DSC_ERR_CRN;
               else
               begin
                  d.crn  = cs[`DSC_CRN_MSB:`DSC_CRN_LSB];
                  d.wadr = q.adr[d.crn];
                  d.wlen = cs[`DSC_LEN_MSB:`DSC_LEN_LSB];
                  d.size = xfer_size(d.wadr[1:0], dev_width, d.wlen);
                  d.tc   = d.wlen < 20'(d.size);
                  d.fsm  = S_SRC;
                  if (sysm && !(q.tv && q.tcrn == d.crn
                                && q.ttag == d.wadr[`DSC_TCE_MSB:`DSC_TCE_LSB]))
                     d.fsm = S_TCE;
               end
            end
         end
         S_TCE:
         begin
            if (!q.req.valid)
            begin
               d.req.valid = 1'b1;
               d.req.addr  = q.tbase + {10'h0, q.wadr[`DSC_TCE_MSB:`DSC_TCE_LSB], 2'h0};
               d.req.write = 1'b0;
               d.req.dev   = 1'b0;
               d.req.sys   = 1'b1;
               d.req.size  = `DSC_ENTRY_BYTES;
               d.req.wdata = 32'h0;
            end
            else if (bus_rsp.err)
            begin
               fail  = 1'b1;
               ecode = `DSC_ERR_TCE;
            end
            else if (bus_rsp.ack)
            begin
               d.req.valid = 1'b0;
               d.real_page_number  = bus_rsp.rdata[31:12];
               d.tv   = 1'b1;
               d.ttag = q.wadr[`DSC_TCE_MSB:`DSC_TCE_LSB];
               d.tcrn = q.crn;
               d.fsm  = S_SRC;
            end
         end
         S_SRC:
         begin
            if (!q.req.valid)
            begin
               // Memory is read first when moving toward the device.
               d.req.valid = 1'b1;
               d.req.addr  = dir ? q.wadr : pa;
               d.req.write = 1'b0;
               d.req.dev   = dir;
               d.req.sys   = sysm & ~dir;
               d.req.size  = q.size;
               d.req.wdata = 32'h0;
            end
            else if (bus_rsp.err)
            begin
               fail  = 1'b1;
               ecode = dir ? `DSC_ERR_DEV : `DSC_ERR_MEM;
            end
            else if (bus_rsp.ack)
            begin
               d.req.valid = 1'b0;
               d.data = bus_rsp.rdata;
               d.fsm  = S_DST;
            end
         end
         S_DST:
         begin
            if (!q.req.valid)
            begin
               d.req.valid = 1'b1;
               d.req.addr  = dir ? pa : q.wadr;
               d.req.write = 1'b1;
               d.req.dev   = ~dir;
               d.req.sys   = sysm & dir;
               d.req.size  = q.size;
               d.req.wdata = q.data;
            end
            else if (bus_rsp.err)
            begin
               fail  = 1'b1;
               ecode = dir ? `DSC_ERR_MEM : `DSC_ERR_DEV;
            end
            else if (bus_rsp.ack)
            begin
               d.req.valid = 1'b0;
               d.tc = 1'b0;
               // The address register and the length field are written back, and the status field too on the last unit.
               d.adr[q.crn] = q.wadr + 32'(q.size);
               d.channel_status_control[q.lvl][`DSC_LEN_MSB:`DSC_LEN_LSB] = q.wlen - 20'(q.size);
               if (q.tc)
                  d.channel_status_control[q.lvl][`DSC_ST_MSB:`DSC_ST_LSB] = `DSC_ST_DIS;
               // A held burst line chains the next transfer without arbitration.
               d.fsm = (q.stab[5] && !q.tc) ? S_CHECK : S_IDLE;
            end
         end
      endcase

      // The address register is left as it was at the failure.
      if (fail)
      begin
         d.req.valid = 1'b0;
         d.tc  = 1'b0;
         d.fsm = S_IDLE;
         d.channel_status_control[q.lvl][`DSC_ST_MSB:`DSC_ST_LSB] = ecode;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register.  Channel words are cleared at reset so a stray grant finds
   // every channel disabled, although software is expected to load them anyway.

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= '0;
         q.tbase <= `DSC_RESET_WORD;
      end
      else if (ce)
         q <= d;
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = q.hrdata;
   assign bus_req   = q.req;
   assign tc        = q.tc;

endmodule

// ===== dsc_channel_ctrl_sva.sv
// Concurrent checks on the ports of the slave DMA channel controller.
`timescale 1ns/1ps
module dsc_channel_ctrl_sva
   import dsc_pkg::*;
(
   input wire logic            hclk,
   input wire logic            hresetn,
   input wire logic            ce,
   input wire logic            hsel,
   input wire logic [1:0]      htrans,
   input wire logic            hwrite,
   input wire logic            hready,
   input wire logic            hreadyout,
   input wire logic            hresp,
   input wire logic [31:0]     hrdata,
   input wire dsc_bus_req_type bus_req,
   input wire dsc_bus_rsp_type bus_rsp,
   input wire logic            tc
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////////
   property p_no_wait;
      hreadyout;
   endproperty
   a_no_wait: assert property (p_no_wait) else $error("wait state");
   property p_okay;
      !hresp;
   endproperty
   a_okay: assert property (p_okay) else $error("error response");
   property p_req_hold;
      bus_req.valid && !bus_rsp.ack && !bus_rsp.err |=> $stable(bus_req);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request moved");
   property p_req_drop;
      bus_req.valid && (bus_rsp.ack || bus_rsp.err) |=> !bus_req.valid;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("request kept");
   property p_tc_rise;
      $rose(tc) |=> bus_req.valid;
   endproperty
   a_tc_rise: assert property (p_tc_rise) else $error("count pulse idle");
   property p_tc_fall;
      $fell(tc) |-> !bus_req.valid && $past(bus_req.valid, 1);
   endproperty
   a_tc_fall: assert property (p_tc_fall) else $error("count pulse late");
   property p_size;
      bus_req.valid |-> bus_req.size inside {3'h1, 3'h2, 3'h4};
   endproperty
   a_size: assert property (p_size) else $error("bad unit size");
   property p_rd_hold;
      !(hsel && hready && htrans[1] && !hwrite && ce) |=> $stable(hrdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   c_tc: cover property ($rose(tc));
   c_err: cover property (bus_req.valid && bus_rsp.err);
   c_sys: cover property (bus_req.valid && bus_req.sys);
endmodule
bind dsc_channel_ctrl dsc_channel_ctrl_sva dsc_channel_ctrl_sva_inst (.hclk, .hresetn, .ce,
   .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .bus_req, .bus_rsp, .tc);

// ===== dsc_bus_model.sv
// Far-side partner: bus memory, system memory and slave device answering cycles.
`timescale 1ns/1ps
module dsc_bus_model
   import dsc_pkg::*;
(
   input  wire logic            hclk,
   input  wire logic            hresetn,
   input  wire dsc_bus_req_type bus_req,
   input  wire logic            err_next,
   output dsc_bus_rsp_type      bus_rsp
);
   logic [1:0] wait_q;
   logic [1:0] seq_q;
   // Delay steps through 0..3 so prompt and slow answers both occur. Data lines carry a
   // changing pattern outside the answer cycle, since nobody holds them.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wait_q <= 2'h0;
         seq_q <= 2'h0;
         bus_rsp <= '0;
      end
      else
      begin
         bus_rsp.ack <= 1'b0;
         bus_rsp.err <= 1'b0;
         bus_rsp.rdata <= {bus_rsp.rdata[30:0], ~bus_rsp.rdata[31]};
         if (bus_req.valid && !bus_rsp.ack && !bus_rsp.err)
         begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == seq_q)
            begin
               wait_q <= 2'h0;
               seq_q <= seq_q + 2'h1;
               bus_rsp.ack <= !err_next;
               bus_rsp.err <= err_next;
               bus_rsp.rdata <= bus_req.addr ^ 32'h5a5a_0000;
            end
         end
      end
   end
endmodule

// ===== dma_slave_channel_controller_tb.sv
// Self-checking testbench of the slave DMA channel controller.
`timescale 1ns/1ps
module dma_slave_channel_controller_tb;
   import dsc_pkg::*;
   localparam int NCH = 4;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, grant_pin = 0, burst_pin = 0;
   logic err_next = 0, vprev = 0, tprev = 0, dwr = 0;
   logic [31:0] haddr = 0, hwdata = 0, lf = 32'h5af60259, hrdata;
   logic [1:0] htrans = 0;
   logic [3:0] level_pin = 0;
   logic [2:0] dev_width = 3'h1;
   logic hreadyout, hresp, tc;
   logic [31:0] madr [2];
   dsc_bus_req_type bus_req;
   dsc_bus_rsp_type bus_rsp;
   int err_total = 0, comparisons = 0, nreq = 0, ntc = 0, nmem = 0;
   always #10 hclk = ~hclk;
   dsc_channel_ctrl #(.NUM_CH(NCH)) dsc_channel_ctrl_inst (.hclk, .hresetn, .ce(1'b1), .hsel,
      .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
      .hrdata, .grant_pin, .level_pin, .burst_pin, .dev_width, .bus_req, .bus_rsp, .tc);
   dsc_bus_model dsc_bus_model_inst (.hclk, .hresetn, .bus_req, .err_next, .bus_rsp);
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge hclk)
   begin
      vprev <= bus_req.valid;
      tprev <= tc;
      if (tc && !tprev) ntc++;
      if (bus_req.valid && !vprev)
      begin
         nreq++;
         if (bus_req.dev) dwr = bus_req.write;
         if (!bus_req.dev && nmem < 2) madr[nmem++] = bus_req.addr;
      end
   end
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [31:0] channel_status_control(input logic s, d, input logic [3:0] n,
                                       input logic [19:0] len);
      return {4'h0, 1'b1, s, 1'b0, d, n, len};
   endfunction
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic edge_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
         if (++n > 50) begin err_total++; end_sim(); end
         @(posedge hclk);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      edge_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      edge_rdy();
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask
   // One grant cycle; level is settled well before grant so the synchroniser sees it.
   task automatic serve(input logic [3:0] ch, input logic b);
      level_pin <= ch;
      burst_pin <= b;
      repeat (8) @(posedge hclk);
      grant_pin <= 1'b1;
      repeat (40) @(posedge hclk);
      grant_pin <= 1'b0;
   endtask
   task automatic run(input logic [3:0] ch, crn, input logic s, d, input logic [31:0] a,
                      input logic [19:0] len, output logic [31:0] st);
      int n;
      nreq = 0;
      ntc = 0;
      nmem = 0;
      n = 0;
      wr(8'h40 | {2'h0, crn, 2'h0}, a);
      wr({2'h0, ch, 2'h0}, channel_status_control(s, d, crn, len));
      wr(`DSC_CMD_OFF, {27'h0, 1'b1, ch});
      do
      begin
         serve(ch, lf[5]);
         lf = nxt(lf);
         bus({2'h0, ch, 2'h0}, 1'b0, 32'h0, st);
         n++;
      end while (st[31:28] == `DSC_ST_EN && n < 80);
      if (n >= 80) begin err_total++; end_sim(); end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] r, a, st, e, x;
      logic [19:0] len;
      logic [3:0] crn;
      logic s, d;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      bus(8'h00, 1'b0, 32'h0, r); chk(r, 32'h0);
      bus(8'h90, 1'b0, 32'h0, r); chk(r, 32'h0);
      wr(`DSC_TBASE_OFF, 32'h0010_0000);
      for (int i = 0; i < 12; i++)
      begin
         lf = nxt(lf);
         a = lf;
         lf = nxt(lf);
         {d, s} = lf[1:0];
         crn = {2'h0, lf[11:10]};
         len = (i == 0) ? 20'h0 : {15'h0, lf[8:4]};
         if (i == 1) a[1:0] = 2'h3;
         dev_width <= (i == 1 || lf[3:2] == 2'h2) ? 3'h4 : {1'b0, lf[3:2] == 2'h1, lf[3:2] == 0};
         run(4'(i % NCH), crn, s, d, a, len, st);
         chk(st, channel_status_control(s, d, crn, 20'hfffff));
         bus(8'h40 | {2'h0, crn, 2'h0}, 1'b0, 32'h0, r); chk(r, a + len + 1);
         chk(ntc, 1);
         chk({31'h0, dwr}, {31'h0, !d});
         e = 32'h0010_0000 + {10'h0, a[31:12], 2'h0};
         chk(madr[0], s ? e : a);
         if (s) chk(madr[1], ((e ^ 32'h5a5a_0000) & 32'hffff_f000) | {20'h0, a[11:0]});
      end
      for (int k = 0; k < 3; k++)
      begin
         s = (k == 0);
         d = (k == 2);
         err_next <= 1'b1;
         run(4'h1, 4'h1, s, d, 32'h0000_2000, 20'h7, st);
         err_next <= 1'b0;
         chk(st, channel_status_control(s, d, 4'h1, 20'h7) | {`DSC_ERR_TCE + 4'(k), 28'h0});
         bus(8'h44, 1'b0, 32'h0, r); chk(r, 32'h0000_2000);
         wr(`DSC_CMD_OFF, 32'h11);
         serve(4'h1, 1'b0);
         bus(8'h04, 1'b0, 32'h0, r); chk(r, st);
         chk(nreq, 1);
         wr(8'h04, channel_status_control(s, d, 4'h1, 20'h7));
      end
      run(4'h2, 4'(NCH), 1'b0, 1'b0, 32'h0, 20'h3, st);
      chk(st, channel_status_control(1'b0, 1'b0, 4'(NCH), 20'h3) | {`DSC_ERR_CRN, 28'h0});
      dev_width <= 3'h1;
      wr(8'h04, channel_status_control(1'b0, 1'b0, 4'h1, 20'h7));
      wr(`DSC_CMD_OFF, 32'h11);
      serve(4'h1, 1'b0);
      wr(`DSC_CMD_OFF, 32'h01);
      x = nreq;
      serve(4'h1, 1'b0);
      chk(nreq, x);
      bus(8'h04, 1'b0, 32'h0, r); chk(r, channel_status_control(1'b0, 1'b0, 4'h1, 20'h6));
      bus(8'h44, 1'b0, 32'h0, r); chk(r, 32'h0000_2001);
      end_sim();
   end
endmodule
